// ### include/wdtps_pkg.sv
// Package for the prescaled watchdog: register map, field layout, timing constants.
`default_nettype none
package wdtps_pkg;
  localparam logic [11:0] WDTPS_CTRL_ADDR    = 12'h08F;   // Register index.
  localparam logic [11:0] WDTPS_STAT_ADDR    = 12'h090;   // Register index.
  localparam int          WDTPS_ADDR_SHIFT   = 2;
  localparam int          WDTPS_TIMER_W      = 14;
  localparam int          WDTPS_PRE_W        = 8;
  localparam int          WDTPS_MC_W         = 4;
  localparam logic [3:0]  WDTPS_MC_LAST      = 4'hB;       // Twelve clocks per cycle.
  localparam int          WDTPS_BIT_EN       = 7;
  localparam int          WDTPS_BIT_RESTART  = 6;
  localparam int          WDTPS_BIT_IDLE     = 5;
  localparam int          WDTPS_PS_HI        = 2;
  localparam logic [7:0]  WDTPS_CTRL_RESET   = 8'h00;
  localparam logic [7:0]  WDTPS_CTRL_WMASK   = 8'hE7;
  localparam logic [WDTPS_TIMER_W-1:0] WDTPS_TIMER_MAX = 14'h3FFF;
  localparam logic [WDTPS_PRE_W-1:0]   WDTPS_PRE_ZERO  = 8'h00;

  typedef struct packed {
    logic       enable;
    logic       restart;
    logic       runIdle;
    logic [2:0] prescaleSel;
  } wdtps_ctrl_type;

  typedef struct packed {
    logic       timeoutSeen;
    logic       running;
    logic [WDTPS_TIMER_W-1:0] timerValue;
  } wdtps_stat_type;
endpackage : wdtps_pkg
`default_nettype wire

// ### rtl/wdtps_divider.sv
// Divider chain for the prescaled watchdog: twelve-clock cycle, prescaler, 14-bit timer.
`default_nettype none
module wdtps_divider
  import wdtps_pkg::*;
(
  input  wire logic                     clk,         // System clock.
  input  wire logic                     rst,         // Asynchronous reset, active high.
  input  wire logic                     countEn,     // Chain advances while high.
  input  wire logic                     clear,       // Synchronous clear of all stages.
  input  wire logic [2:0]               prescaleSel, // Prescaler select field.
  output logic                          expire,      // One-cycle pulse on time-out.
  output logic [wdtps_pkg::WDTPS_TIMER_W-1:0] timer  // Current timer value.
);
  import wdtps_pkg::*;

  logic [WDTPS_MC_W-1:0]  cycleCnt;
  logic [WDTPS_PRE_W-1:0] preCnt;
  logic                   cycleTick;
  logic                   preTick;

  // Decode maps select codes to the divide ratio minus one; note that codes 1 and 2 are swapped.
  function automatic logic [WDTPS_PRE_W-1:0] preLast(input logic [2:0] sel);
    case (sel)
      3'h0:    preLast = 8'h01;
      3'h2:    preLast = 8'h03;
      3'h1:    preLast = 8'h07;
      3'h3:    preLast = 8'h0F;
      3'h4:    preLast = 8'h1F;
      3'h5:    preLast = 8'h3F;
      3'h6:    preLast = 8'h7F;
      default: preLast = 8'hFF;
    endcase
  endfunction : preLast

  assign cycleTick = countEn && (cycleCnt == WDTPS_MC_LAST);
  assign preTick   = cycleTick && (preCnt >= preLast(prescaleSel));

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cycleCnt <= '0;
    end else if (clear || cycleTick) begin
      cycleCnt <= '0;
    end else if (countEn) begin
      cycleCnt <= cycleCnt + 4'h1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      preCnt <= WDTPS_PRE_ZERO;
    end else if (clear || preTick) begin
      preCnt <= WDTPS_PRE_ZERO;
    end else if (cycleTick) begin
      preCnt <= preCnt + 8'h01;
    end
  end

  // The timer wraps after expiring, so the chain stays free-running.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      timer  <= '0;
      expire <= 1'b0;
    end else begin
      expire <= preTick && (timer == WDTPS_TIMER_MAX) && !clear;
      if (clear) begin
        timer <= '0;
      end else if (preTick) begin
        timer <= timer + 14'h0001;
      end
    end
  end
endmodule : wdtps_divider
`default_nettype wire

// ### rtl/wdtps_watchdog.sv
// Top of the prescaled watchdog: APB register slave, idle gating and reset request.
`default_nettype none
module wdtps_watchdog
  import wdtps_pkg::*;
(
  input  wire logic        clk,           // System clock, 10 MHz.
  input  wire logic        rst,           // Asynchronous reset, active high.
  input  wire logic        idleMode,      // Processor idle, same clock domain.
  input  wire logic        psel,          // APB select.
  input  wire logic        penable,       // APB enable.
  input  wire logic        pwrite,        // APB direction.
  input  wire logic [31:0] paddr,         // APB byte address.
  input  wire logic [31:0] pwdata,        // APB write data.
  output logic      [31:0] prdata,        // APB read data.
  output logic             pready,        // APB ready.
  output logic             pslverr,       // APB error on unmapped address.
  output logic             resetRequest   // One-cycle system reset request.
);
  import wdtps_pkg::*;

  wdtps_ctrl_type ctrl;
  logic           timeoutSeen;
  logic           countEn;
  logic           expire;
  logic [WDTPS_TIMER_W-1:0] timer;
  logic           setupPhase;
  logic           isWrite;
  logic           isRead;
  logic           hitCtrl;
  logic           hitStat;
  logic [7:0]     ctrlByte;
  wdtps_stat_type stat;

  // Full-address decode, so aliases above the register window are refused, not folded in.
  function automatic logic regHit(input logic [31:0] addr, input logic [11:0] index);
    regHit = (addr[31:WDTPS_ADDR_SHIFT] == {18'h00000, index}) && (addr[1:0] == 2'h0);
  endfunction : regHit

  assign hitCtrl    = regHit(paddr, WDTPS_CTRL_ADDR);
  assign hitStat    = regHit(paddr, WDTPS_STAT_ADDR);
  // The slave answers in the setup cycle's following access cycle, so pready pulses there.
  assign setupPhase = psel && !penable;
  assign isWrite    = psel && penable && pready && pwrite;
  assign isRead     = setupPhase && !pwrite;
  assign ctrlByte   = {ctrl.enable, ctrl.restart, ctrl.runIdle, 2'h0, ctrl.prescaleSel};
  assign stat       = '{timeoutSeen: timeoutSeen, running: countEn, timerValue: timer};

  // Idle stops only the processor clock; the chain sees the same clock and idle just gates it.
  assign countEn = ctrl.enable && (ctrl.runIdle || !idleMode);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl <= '{enable:      WDTPS_CTRL_RESET[WDTPS_BIT_EN],
                restart:     WDTPS_CTRL_RESET[WDTPS_BIT_RESTART],
                runIdle:     WDTPS_CTRL_RESET[WDTPS_BIT_IDLE],
                prescaleSel: WDTPS_CTRL_RESET[WDTPS_PS_HI:0]};
    end else if (isWrite && hitCtrl) begin
      ctrl.enable      <= pwdata[WDTPS_BIT_EN];
      ctrl.restart     <= pwdata[WDTPS_BIT_RESTART];
      ctrl.runIdle     <= pwdata[WDTPS_BIT_IDLE];
      ctrl.prescaleSel <= pwdata[WDTPS_PS_HI:0];
    end else if (ctrl.restart) begin
      ctrl.restart <= 1'b0;
    end
  end

  wdtps_divider u_divider (
    .clk         (clk),
    .rst         (rst),
    .countEn     (countEn),
    .clear       (ctrl.restart),
    .prescaleSel (ctrl.prescaleSel),
    .expire      (expire),
    .timer       (timer)
  );

  // Sticky flag so software can tell a watchdog reset from others; a status read clears it, set wins.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      timeoutSeen <= 1'b0;
    end else if (expire && ctrl.enable) begin
      timeoutSeen <= 1'b1;
    end else if (psel && penable && pready && !pwrite && hitStat) begin
      timeoutSeen <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      resetRequest <= 1'b0;
    end else begin
      resetRequest <= expire && ctrl.enable;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= setupPhase;
      pslverr <= setupPhase && !(hitCtrl || hitStat);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prdata <= 32'h00000000;
    end else if (isRead && hitCtrl) begin
      prdata <= {24'h000000, ctrlByte & WDTPS_CTRL_WMASK};
    end else if (isRead && hitStat) begin
      prdata <= {16'h0000, stat};
    end else if (setupPhase) begin
      prdata <= 32'h00000000;
    end
  end
endmodule : wdtps_watchdog
`default_nettype wire

// ### tb/wdtps_checker.sv
// Port checker for the prescaled watchdog.
`default_nettype none
module wdtps_checker
  import wdtps_pkg::*;
(
  input wire logic        clk,          // Clock.
  input wire logic        rst,          // Reset.
  input wire logic        idleMode,     // Idle.
  input wire logic        psel,         // Select.
  input wire logic        penable,      // Enable.
  input wire logic        pwrite,       // Direction.
  input wire logic [31:0] paddr,        // Address.
  input wire logic [31:0] pwdata,       // Write data.
  input wire logic [31:0] prdata,       // Read data.
  input wire logic        pready,       // Ready.
  input wire logic        pslverr,      // Error.
  input wire logic        resetRequest  // Reset request.
);
  import wdtps_pkg::*;
  localparam logic [31:0] CTRLB = 32'(WDTPS_CTRL_ADDR) << WDTPS_ADDR_SHIFT;
  localparam logic [31:0] STATB = 32'(WDTPS_STAT_ADDR) << WDTPS_ADDR_SHIFT;
  logic mapped;
  logic ctrlRd;
  logic ctrlWr;
  logic en;
  assign mapped = (paddr == CTRLB) || (paddr == STATB);
  assign ctrlRd = pready && !pwrite && (paddr == CTRLB);
  assign ctrlWr = psel && penable && pready && pwrite && (paddr == CTRLB);
  // Shadow of the enable bit, so a request can be tied to what software wrote.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      en <= 1'b0;
    end else if (ctrlWr) begin
      en <= pwdata[WDTPS_BIT_EN];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_in_access: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_unmapped_err: assert property (psel && !penable && !mapped |=> pslverr)
    else $error("unmapped access not refused");
  a_mapped_ok: assert property (psel && !penable && mapped |=> !pslverr)
    else $error("mapped access refused");
  a_reserved_zero: assert property (ctrlRd |-> prdata[31:8] == 24'h000000 && prdata[4:3] == 2'h0)
    else $error("reserved control bits not zero");
  // A read whose setup directly follows a control write may still see the restart bit.
  a_restart_self_clear: assert property (ctrlRd && !$past(ctrlWr, 2)
    |-> !prdata[WDTPS_BIT_RESTART])
    else $error("restart bit did not clear");
  a_req_needs_enable: assert property (!en [*3] |-> !resetRequest)
    else $error("reset request while disabled");
  a_req_single_pulse: assert property (resetRequest |=> !resetRequest)
    else $error("reset request longer than one cycle");
  cover property (ctrlRd);
  cover property (pslverr);
  cover property (en && idleMode);
endmodule : wdtps_checker
bind wdtps_watchdog wdtps_checker wdtps_checker_i (.clk, .rst, .idleMode, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .resetRequest);
`default_nettype wire

// ### tb/wdtps_watchdog_tb.sv
// Self-checking bench for the prescaled watchdog over APB.
`default_nettype none
`define CHK(n, e, g) begin checkCount++; if ((g) !== (e)) begin mismatches++; \
  $display("wrong value %s expected %0h seen %0h", n, e, g); end end
module wdtps_watchdog_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import wdtps_pkg::*;
  localparam logic [31:0] CTRLB = 32'(WDTPS_CTRL_ADDR) << WDTPS_ADDR_SHIFT;
  localparam logic [31:0] STATB = 32'(WDTPS_STAT_ADDR) << WDTPS_ADDR_SHIFT;
  logic        clk, rst, idleMode, psel, penable, pwrite, pready, pslverr, resetRequest, rerr;
  logic [31:0] paddr, pwdata, prdata, rdata;
  int          mismatches, checkCount, reqCount;
  int          divs[8] = '{2, 8, 4, 16, 32, 64, 128, 256};
  wdtps_watchdog wdtps_watchdog_i (.clk, .rst, .idleMode, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .resetRequest);
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Software restarts in time throughout, so any request seen here is a fault.
  always @(posedge clk) begin
    if (resetRequest !== 1'b0) begin
      reqCount++;
    end
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checkCount, mismatches);
    if (mismatches == 0 && checkCount > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : tally_and_finish
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rdata = prdata;
    rerr  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  initial begin
    {rst, idleMode, psel, penable, pwrite, paddr, pwdata} = {1'b1, 68'h0};
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    apb(1'b0, CTRLB, 0); `CHK("ctrl reset", 32'h0, rdata)
    apb(1'b0, STATB, 0); `CHK("status reset", 32'h0, rdata)
    apb(1'b1, CTRLB, 32'h40);
    apb(1'b0, STATB, 0); `CHK("restart after reset", 32'h0, rdata)
    apb(1'b1, CTRLB, 32'hFF);
    apb(1'b0, CTRLB, 0); `CHK("ctrl fields", 32'hA7, rdata)
    apb(1'b0, 32'h4, 0); `CHK("unmapped error", 1'b1, rerr)
    `CHK("unmapped data", 32'h0, rdata)
    // Four timer steps take 48 clocks times the divide ratio; the margin stays below a fifth step.
    foreach (divs[i]) begin
      apb(1'b1, CTRLB, 32'hC0 | i);
      repeat (48 * divs[i] + 12) @(posedge clk);
      apb(1'b0, STATB, 0); `CHK("ticks", 32'h4004, rdata)
    end
    apb(1'b1, CTRLB, 32'hC7);
    apb(1'b0, STATB, 0); `CHK("restart", 14'h0, rdata[13:0])
    apb(1'b1, CTRLB, 32'hC0);
    repeat (100) @(posedge clk);
    apb(1'b1, CTRLB, 32'h00);
    // Four prescaled steps of 24 clocks land before the disable write does.
    apb(1'b0, STATB, 0); `CHK("stopped", 32'h0004, rdata)
    repeat (200) @(posedge clk);
    apb(1'b0, STATB, 0); `CHK("held", 32'h0004, rdata)
    idleMode <= 1'b1;
    apb(1'b1, CTRLB, 32'hC0);
    repeat (200) @(posedge clk);
    apb(1'b0, STATB, 0); `CHK("idle halt", 32'h0, rdata)
    apb(1'b1, CTRLB, 32'hE0);
    repeat (108) @(posedge clk);
    apb(1'b0, STATB, 0); `CHK("idle run", 32'h4004, rdata)
    idleMode <= 1'b0;
    `CHK("reset requests", 0, reqCount)
    tally_and_finish();
  end
  initial begin
    repeat (40000) @(posedge clk);
    mismatches++;
    tally_and_finish();
  end
endmodule : wdtps_watchdog_tb
`default_nettype wire
